// ---- inc/cycle_term_pkg.sv ----
// Shared constants and types for cycle termination and interrupt input handling
package cycle_term_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_T1   = 2'b01,
        ST_T2   = 2'b10
    } bus_state_e;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned BEAT_W = 2;
    localparam int unsigned VECTOR_W = 8;

    // Synchroniser lanes
    localparam int unsigned SYNC_W = 3;
    localparam int unsigned SYNC_RESET = 0;
    localparam int unsigned SYNC_MASKABLE_IRQ = 1;
    localparam int unsigned SYNC_NMI = 2;
    // Reset lane starts asserted so the core never sees a false release
    localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 3'h1;

    // Acknowledge sequencing phases
    localparam logic [1:0] INTA_NONE = 2'h0;
    localparam logic [1:0] INTA_FIRST = 2'h1;
    localparam logic [1:0] INTA_SECOND = 2'h2;

    // Least low time before a qualifying edge, in clock periods
    localparam int unsigned NMI_LOW_MIN_CLK = 4;
    localparam int unsigned NMI_CNT_W = 3;
    localparam logic [NMI_CNT_W-1:0] NMI_LOW_MIN = NMI_CNT_W'(NMI_LOW_MIN_CLK);

    localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [VECTOR_W-1:0] VECTOR_RESET = 8'h00;

endpackage : cycle_term_pkg

// ---- inc/irq_pins_if.sv ----
// Synchronised interrupt and reset pin levels shared between the internal modules
`timescale 1ns/100ps
interface irq_pins_if;
    logic reset_s;
    logic maskable_irq_s;
    logic nmi_s;
    logic nmi_rise;

    modport sync (output reset_s, output maskable_irq_s, output nmi_s);
    modport edge_det (input nmi_s, output nmi_rise);
    modport core (input reset_s, input maskable_irq_s, input nmi_rise);
endinterface : irq_pins_if

// ---- core/pin_sync.sv ----
// Two-stage synchroniser for the asynchronous reset and interrupt pins
`timescale 1ns/100ps
module pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [cycle_term_pkg::SYNC_W-1:0] i_async,
    irq_pins_if.sync bus
);

    logic [cycle_term_pkg::SYNC_W-1:0] meta_q;
    logic [cycle_term_pkg::SYNC_W-1:0] sync_q;

    ////////////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    genvar g;
    generate
        for (g = 0; g < cycle_term_pkg::SYNC_W; g++)
        begin : g_lane
            logic meta_d;
            logic sync_d;
            always_comb
            begin
                meta_d = i_async[g];
                sync_d = meta_q[g];
            end
            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    meta_q[g] <= cycle_term_pkg::SYNC_RESET_VAL[g];
                    sync_q[g] <= cycle_term_pkg::SYNC_RESET_VAL[g];
                end
                else
                begin
                    meta_q[g] <= meta_d;
                    sync_q[g] <= sync_d;
                end
            end
        end
    endgenerate

    assign bus.reset_s = sync_q[cycle_term_pkg::SYNC_RESET];
    assign bus.maskable_irq_s = sync_q[cycle_term_pkg::SYNC_MASKABLE_IRQ];
    assign bus.nmi_s = sync_q[cycle_term_pkg::SYNC_NMI];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_SYNC_LATENCY: assert property (
        $past(i_rst_n, 2) |-> (sync_q == $past(i_async, 2)))
        else $error("synchronised level does not follow pin after two clocks");

endmodule : pin_sync

// ---- core/nmi_edge_qualifier.sv ----
// Rising-edge detector that only fires after a sufficiently long low period
`timescale 1ns/100ps
module nmi_edge_qualifier (
    input wire logic i_clk,
    input wire logic i_rst_n,
    irq_pins_if.edge_det bus
);

    logic [cycle_term_pkg::NMI_CNT_W-1:0] low_cnt_q;
    logic [cycle_term_pkg::NMI_CNT_W-1:0] low_cnt_d;
    logic prev_q;
    logic prev_d;
    logic rise_q;
    logic rise_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter saturates so an arbitrarily long low still qualifies
    always_comb
    begin
        prev_d = bus.nmi_s;
        low_cnt_d = low_cnt_q;
        if (bus.nmi_s)
        begin
            low_cnt_d = '0;
        end
        else if (low_cnt_q < cycle_term_pkg::NMI_LOW_MIN)
        begin
            low_cnt_d = low_cnt_q + 3'h1;
        end
        rise_d = bus.nmi_s && !prev_q && (low_cnt_q >= cycle_term_pkg::NMI_LOW_MIN);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            low_cnt_q <= '0;
            prev_q <= 1'b1;
            rise_q <= 1'b0;
        end
        else
        begin
            low_cnt_q <= low_cnt_d;
            prev_q <= prev_d;
            rise_q <= rise_d;
        end
    end

    assign bus.nmi_rise = rise_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_low_then_high;
        (!bus.nmi_s) [*4] ##1 bus.nmi_s;
    endsequence

    AST_NMI_QUALIFIED_FIRES: assert property (
        s_low_then_high |=> rise_q)
        else $error("edge after four low clocks was not detected");

    AST_NMI_SHORT_LOW_IGNORED: assert property (
        rise_q |-> ($past(bus.nmi_s, 1) && !$past(bus.nmi_s, 2) && !$past(bus.nmi_s, 5)))
        else $error("edge fired without four low clocks before it");

endmodule : nmi_edge_qualifier

// ---- core/cycle_termination_and_irq_inputs.sv ----
// Bus cycle termination, burst sequencing, reset and interrupt pin handling
// Behaviour
// - Non-burst ready ends the cycle; read data valid or write data taken.
// - Non-burst ready is ignored while idle and at end of first clock.
// - Non-burst ready still honoured while address float request is high.
// - Burst ready ends beats of a burst; ignored idle and in first clock.
// - Burst ready sampled from second clock on; data latched on each sampled beat.
// - Both readies together: burst ready ignored, burst ends at once.
// - Burst-final low when next burst ready ends the cycle; also in non-burst.
// - Burst-final is active low and floats while the bus is held away.
// - Reset pin forces a defined initial state; execution starts after release.
// - Reset pin accepted asynchronously and synchronised internally.
// - Maskable interrupt serviced only when the enable flag is set.
// - Accepted maskable interrupt runs two back-to-back locked acknowledge cycles.
// - Maskable request is an active-high asynchronous level, synchronised first.
// - Non-maskable interrupt fires on rising edge after four low clocks.
// - Non-maskable input is synchronised before edge detection.
// - Lock goes active in first clock of first locked cycle, off after last.
`timescale 1ns/100ps
module cycle_termination_and_irq_inputs (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_pin,
    input wire logic i_maskable_irq,
    input wire logic i_nmi,
    input wire logic i_flags_if,
    input wire logic i_nmi_taken,
    input wire logic i_cycle_req,
    input wire logic i_cycle_burst,
    input wire logic [cycle_term_pkg::BEAT_W-1:0] i_cycle_beats,
    input wire logic i_rdy_n,
    input wire logic i_burst_ready_n,
    input wire logic i_address_float_request,
    input wire logic i_bus_hold,
    input wire logic [cycle_term_pkg::DATA_W-1:0] i_data,
    output logic o_core_reset,
    output logic o_busy,
    output logic o_inta_active,
    output logic o_burst_final_n,
    output logic o_burst_final_oe,
    output logic o_lock_n,
    output logic o_lock_oe,
    output logic o_data_valid,
    output logic [cycle_term_pkg::DATA_W-1:0] o_data,
    output logic o_cycle_done,
    output logic o_irq_taken,
    output logic [cycle_term_pkg::VECTOR_W-1:0] o_irq_vector,
    output logic o_nmi_pending
);

    irq_pins_if pins ();

    pin_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_nmi, i_maskable_irq, i_reset_pin}),
        .bus(pins.sync)
    );

    nmi_edge_qualifier u_nmi (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(pins.edge_det)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle state
    cycle_term_pkg::bus_state_e state_q;
    cycle_term_pkg::bus_state_e state_d;
    logic burst_q;
    logic burst_d;
    logic [cycle_term_pkg::BEAT_W-1:0] beats_left_q;
    logic [cycle_term_pkg::BEAT_W-1:0] beats_left_d;
    logic [1:0] inta_phase_q;
    logic [1:0] inta_phase_d;
    logic core_reset_q;
    logic core_reset_d;

    // Registered outputs
    logic burst_final_n_q;
    logic burst_final_n_d;
    logic burst_final_oe_q;
    logic burst_final_oe_d;
    logic lock_n_q;
    logic lock_n_d;
    logic lock_oe_q;
    logic lock_oe_d;
    logic data_valid_q;
    logic data_valid_d;
    logic [cycle_term_pkg::DATA_W-1:0] data_q;
    logic [cycle_term_pkg::DATA_W-1:0] data_d;
    logic cycle_done_q;
    logic cycle_done_d;
    logic irq_taken_q;
    logic irq_taken_d;
    logic [cycle_term_pkg::VECTOR_W-1:0] vector_q;
    logic [cycle_term_pkg::VECTOR_W-1:0] vector_d;
    logic nmi_pending_q;
    logic nmi_pending_d;
    logic busy_q;
    logic busy_d;
    logic inta_active_q;
    logic inta_active_d;

    logic launch_irq;
    logic launch_cpu;
    logic rdy_seen;
    logic burst_ready_n_seen;
    logic cycle_end;

    ////////////////////////////////////////////////////////////////////////////////
    // A new cycle needs the address bus, so holds block launch but never termination
    always_comb
    begin
        launch_irq = (state_q == cycle_term_pkg::ST_IDLE) && !core_reset_q && !pins.reset_s
            && (inta_phase_q == cycle_term_pkg::INTA_NONE) && !i_bus_hold
            && !i_address_float_request && pins.maskable_irq_s && i_flags_if;
        launch_cpu = (state_q == cycle_term_pkg::ST_IDLE) && !core_reset_q && !pins.reset_s
            && (inta_phase_q == cycle_term_pkg::INTA_NONE) && !i_bus_hold
            && !i_address_float_request && !launch_irq && i_cycle_req;
        // Readies only count in the second and later clocks
        rdy_seen = (state_q == cycle_term_pkg::ST_T2) && !i_rdy_n;
        burst_ready_n_seen = (state_q == cycle_term_pkg::ST_T2) && burst_q && !i_burst_ready_n;
        cycle_end = rdy_seen || (burst_ready_n_seen && (beats_left_q == cycle_term_pkg::BEAT_LAST));
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_d = state_q;
        burst_d = burst_q;
        beats_left_d = beats_left_q;
        inta_phase_d = inta_phase_q;
        core_reset_d = pins.reset_s;
        lock_n_d = lock_n_q;
        data_valid_d = 1'b0;
        data_d = data_q;
        cycle_done_d = 1'b0;
        irq_taken_d = 1'b0;
        vector_d = vector_q;
        nmi_pending_d = nmi_pending_q;
        if (i_nmi_taken)
        begin
            nmi_pending_d = 1'b0;
        end
        if (pins.nmi_rise)
        begin
            nmi_pending_d = 1'b1;
        end
        case (state_q)
            cycle_term_pkg::ST_IDLE:
            begin
                if (launch_irq)
                begin
                    state_d = cycle_term_pkg::ST_T1;
                    burst_d = 1'b0;
                    beats_left_d = cycle_term_pkg::BEAT_LAST;
                    inta_phase_d = cycle_term_pkg::INTA_FIRST;
                    lock_n_d = 1'b0;
                end
                else if (launch_cpu)
                begin
                    state_d = cycle_term_pkg::ST_T1;
                    burst_d = i_cycle_burst && (i_cycle_beats != cycle_term_pkg::BEAT_LAST);
                    beats_left_d = i_cycle_burst ? i_cycle_beats : cycle_term_pkg::BEAT_LAST;
                end
            end
            cycle_term_pkg::ST_T1:
            begin
                state_d = cycle_term_pkg::ST_T2;
            end
            cycle_term_pkg::ST_T2:
            begin
                if (rdy_seen || burst_ready_n_seen)
                begin
                    data_valid_d = 1'b1;
                    data_d = i_data;
                end
                if (cycle_end)
                begin
                    state_d = cycle_term_pkg::ST_IDLE;
                    burst_d = 1'b0;
                    beats_left_d = cycle_term_pkg::BEAT_LAST;
                    if (inta_phase_q == cycle_term_pkg::INTA_FIRST)
                    begin
                        // Second acknowledge follows at once, still locked
                        state_d = cycle_term_pkg::ST_T1;
                        inta_phase_d = cycle_term_pkg::INTA_SECOND;
                    end
                    else if (inta_phase_q == cycle_term_pkg::INTA_SECOND)
                    begin
                        inta_phase_d = cycle_term_pkg::INTA_NONE;
                        lock_n_d = 1'b1;
                        irq_taken_d = 1'b1;
                        vector_d = i_data[cycle_term_pkg::VECTOR_W-1:0];
                    end
                    else
                    begin
                        cycle_done_d = 1'b1;
                    end
                end
                else if (burst_ready_n_seen)
                begin
                    beats_left_d = beats_left_q - cycle_term_pkg::BEAT_ONE;
                end
            end
            default:
            begin
                state_d = cycle_term_pkg::ST_IDLE;
            end
        endcase
        // Synchronised reset overrides everything except the data and vector latches and the two output enables, and leaves a known state
        if (pins.reset_s)
        begin
            state_d = cycle_term_pkg::ST_IDLE;
            burst_d = 1'b0;
            beats_left_d = cycle_term_pkg::BEAT_LAST;
            inta_phase_d = cycle_term_pkg::INTA_NONE;
            lock_n_d = 1'b1;
            data_valid_d = 1'b0;
            cycle_done_d = 1'b0;
            irq_taken_d = 1'b0;
            nmi_pending_d = 1'b0;
        end
        // Burst-final reflects the cycle about to be in progress
        burst_final_n_d = !((state_d != cycle_term_pkg::ST_IDLE)
            && (!burst_d || (beats_left_d == cycle_term_pkg::BEAT_LAST)));
        burst_final_oe_d = !i_bus_hold;
        lock_oe_d = !i_bus_hold;
        busy_d = (state_d != cycle_term_pkg::ST_IDLE);
        inta_active_d = (inta_phase_d != cycle_term_pkg::INTA_NONE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= cycle_term_pkg::ST_IDLE;
            burst_q <= 1'b0;
            beats_left_q <= cycle_term_pkg::BEAT_LAST;
            inta_phase_q <= cycle_term_pkg::INTA_NONE;
            core_reset_q <= 1'b1;
            burst_final_n_q <= 1'b1;
            burst_final_oe_q <= 1'b0;
            lock_n_q <= 1'b1;
            lock_oe_q <= 1'b0;
            data_valid_q <= 1'b0;
            data_q <= cycle_term_pkg::DATA_RESET;
            cycle_done_q <= 1'b0;
            irq_taken_q <= 1'b0;
            vector_q <= cycle_term_pkg::VECTOR_RESET;
            nmi_pending_q <= 1'b0;
            busy_q <= 1'b0;
            inta_active_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            burst_q <= burst_d;
            beats_left_q <= beats_left_d;
            inta_phase_q <= inta_phase_d;
            core_reset_q <= core_reset_d;
            burst_final_n_q <= burst_final_n_d;
            burst_final_oe_q <= burst_final_oe_d;
            lock_n_q <= lock_n_d;
            lock_oe_q <= lock_oe_d;
            data_valid_q <= data_valid_d;
            data_q <= data_d;
            cycle_done_q <= cycle_done_d;
            irq_taken_q <= irq_taken_d;
            vector_q <= vector_d;
            nmi_pending_q <= nmi_pending_d;
            busy_q <= busy_d;
            inta_active_q <= inta_active_d;
        end
    end

    assign o_core_reset = core_reset_q;
    assign o_busy = busy_q;
    assign o_inta_active = inta_active_q;
    assign o_burst_final_n = burst_final_n_q;
    assign o_burst_final_oe = burst_final_oe_q;
    assign o_lock_n = lock_n_q;
    assign o_lock_oe = lock_oe_q;
    assign o_data_valid = data_valid_q;
    assign o_data = data_q;
    assign o_cycle_done = cycle_done_q;
    assign o_irq_taken = irq_taken_q;
    assign o_irq_vector = vector_q;
    assign o_nmi_pending = nmi_pending_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_ack_first_done;
        (state_q == cycle_term_pkg::ST_T2) && (inta_phase_q == cycle_term_pkg::INTA_FIRST)
            && !i_rdy_n && !pins.reset_s;
    endsequence

    sequence s_ack_second_done;
        (state_q == cycle_term_pkg::ST_T2) && (inta_phase_q == cycle_term_pkg::INTA_SECOND)
            && !i_rdy_n && !pins.reset_s;
    endsequence

    AST_RDY_IGNORED_EARLY: assert property (
        (state_q != cycle_term_pkg::ST_T2) |=> !data_valid_q)
        else $error("ready taken while idle or in first clock");

    AST_RDY_ENDS_CYCLE: assert property (
        ((state_q == cycle_term_pkg::ST_T2) && !i_rdy_n && !pins.reset_s)
        |=> (data_valid_q && (state_q != cycle_term_pkg::ST_T2)))
        else $error("non-burst ready did not end the cycle");

    AST_RDY_IN_ADDRESS_FLOAT_REQUEST: assert property (
        ((state_q == cycle_term_pkg::ST_T2) && !i_rdy_n && i_address_float_request
            && !pins.reset_s) |=> (data_valid_q && (data_q == $past(i_data))))
        else $error("ready ignored under address float request");

    AST_BURST_READY_N_STROBE: assert property (
        ((state_q == cycle_term_pkg::ST_T2) && burst_q && i_rdy_n && !i_burst_ready_n
            && !pins.reset_s) |=> (data_valid_q && (data_q == $past(i_data))))
        else $error("burst beat data not latched");

    AST_RDY_ABORTS_BURST: assert property (
        ((state_q == cycle_term_pkg::ST_T2) && burst_q && !i_rdy_n && !i_burst_ready_n
            && (beats_left_q != cycle_term_pkg::BEAT_LAST) && !pins.reset_s)
        |=> ((state_q == cycle_term_pkg::ST_IDLE) && cycle_done_q))
        else $error("burst not aborted when both readies asserted");

    AST_BURST_FINAL_N_MATCHES_BEAT: assert property (
        (state_q != cycle_term_pkg::ST_IDLE)
        |-> (o_burst_final_n == (burst_q && (beats_left_q != cycle_term_pkg::BEAT_LAST))))
        else $error("burst-final does not mark the last beat");

    AST_BURST_FINAL_N_FLOATS: assert property (
        i_bus_hold |=> (!o_burst_final_oe && !o_lock_oe))
        else $error("burst-final driven during bus hold");

    AST_RESET_STATE: assert property (
        pins.reset_s |=> ((state_q == cycle_term_pkg::ST_IDLE) && o_lock_n && o_core_reset
            && !o_busy && !o_nmi_pending))
        else $error("reset did not force the initial state");

    AST_RESET_SYNC: assert property (
        (i_reset_pin [*3]) |=> o_core_reset)
        else $error("held reset pin not recognised after synchronisation");

    AST_IRQ_MASKED: assert property (
        (!i_flags_if && (inta_phase_q == cycle_term_pkg::INTA_NONE))
        |=> (inta_phase_q == cycle_term_pkg::INTA_NONE))
        else $error("acknowledge started with interrupts disabled");

    AST_INTA_BACK_TO_BACK: assert property (
        s_ack_first_done |=> ((state_q == cycle_term_pkg::ST_T1) && !o_lock_n
            && (inta_phase_q == cycle_term_pkg::INTA_SECOND)))
        else $error("second locked acknowledge did not follow");

    AST_LOCK_FIRST_CLOCK: assert property (
        launch_irq |=> ((state_q == cycle_term_pkg::ST_T1) && !o_lock_n))
        else $error("lock not active in first clock of locked cycle");

    AST_LOCK_RELEASE: assert property (
        s_ack_second_done |=> (o_lock_n && o_irq_taken && !o_inta_active))
        else $error("lock not released after last locked cycle");

    AST_NMI_PENDING: assert property (
        pins.nmi_rise && !pins.reset_s |=> o_nmi_pending)
        else $error("qualified edge lost against clear");

endmodule : cycle_termination_and_irq_inputs

// ---- tb/sys_bus_model.sv ----
// Behavioural system-side controller that terminates the processor's bus cycles
`timescale 1ns/100ps
module sys_bus_model (
    input wire logic i_clk,
    input wire logic i_busy,
    input wire logic i_burst,
    input wire logic i_early,
    input wire logic i_both,
    input wire logic [1:0] i_wait,
    output logic o_rdy_n,
    output logic o_burst_ready_n,
    output logic [31:0] o_data
);
    logic [2:0] cnt_q;
    logic go;

    ////////////////////////////////////////
    initial
    begin
        {o_rdy_n, o_burst_ready_n, o_data, cnt_q} = {2'h3, 32'h0000_0000, 3'h0};
    end

    // Early mode holds ready low even while idle and in the first clock
    assign go = i_early | (i_busy & (cnt_q >= {1'h0, i_wait}));

    always @(posedge i_clk)
    begin
        cnt_q <= i_busy ? cnt_q + 3'h1 : 3'h0;
        o_rdy_n <= ~(go & (~i_burst | i_both));
        o_burst_ready_n <= ~(go & i_burst);
        // A bus not carrying valid data keeps toggling, never the last word
        o_data <= go ? $urandom : ~o_data;
    end
endmodule : sys_bus_model

// ---- tb/tb_cycle_termination_and_irq_inputs.sv ----
// Self-checking bench for cycle termination and interrupt pin handling
`timescale 1ns/100ps
module tb_cycle_termination_and_irq_inputs;
    logic clk = 1'h0;
    logic rst_n, rstp, irq, nmi, fl, nt, req, bu, mb, afr, hold, early, both;
    logic [1:0] bt, w;
    logic cr, busy, ia, bf, bfoe, lk, lkoe, dv, done, it, np, rdy, burst_ready_n;
    logic [31:0] od, d, dp;
    logic [7:0] vec;
    int nv;
    int failures = 0;
    int checked = 0;

    always #50 clk = ~clk;

    cycle_termination_and_irq_inputs u_cycle_termination_and_irq_inputs (
        .i_clk(clk), .i_rst_n(rst_n), .i_reset_pin(rstp), .i_maskable_irq(irq),
        .i_nmi(nmi), .i_flags_if(fl), .i_nmi_taken(nt), .i_cycle_req(req),
        .i_cycle_burst(bu), .i_cycle_beats(bt), .i_rdy_n(rdy), .i_burst_ready_n(burst_ready_n),
        .i_address_float_request(afr), .i_bus_hold(hold), .i_data(d),
        .o_core_reset(cr), .o_busy(busy), .o_inta_active(ia), .o_burst_final_n(bf),
        .o_burst_final_oe(bfoe), .o_lock_n(lk), .o_lock_oe(lkoe), .o_data_valid(dv),
        .o_data(od), .o_cycle_done(done), .o_irq_taken(it), .o_irq_vector(vec),
        .o_nmi_pending(np));

    sys_bus_model u_sys_bus_model (.i_clk(clk), .i_busy(busy), .i_burst(mb),
        .i_early(early), .i_both(both), .i_wait(w), .o_rdy_n(rdy),
        .o_burst_ready_n(burst_ready_n), .o_data(d));

    ////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'h1)
        begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk

    task end_sim;
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic to_fail;
        failures++;
        $display("CHECK FAILED %0t timeout", $time);
        end_sim();
    endtask : to_fail

    task automatic wait_run;
        for (int i = 0; cr !== 1'h0; i++)
        begin
            if (i > 10) to_fail();
            @(posedge clk);
            #1;
        end
    endtask : wait_run

    // One cycle; abort makes the far side return both readies together
    task automatic run_cyc(input logic b, input logic [1:0] n, ws, input logic e, a);
        int nd, first;
        logic sb;
        nv = 0;
        nd = 0;
        first = 0;
        sb = b & (n != 2'h0);
        @(posedge clk);
        {bu, bt, w, early, both, mb, afr, req} <= {b, n, ws, e, a, sb, 2'h1};
        #1 dp = d;
        for (int i = 1; !(nv > 0 && busy === 1'h0); i++)
        begin
            if (i > 40) to_fail();
            @(posedge clk);
            req <= 1'h0;
            afr <= 1'($urandom);
            #1;
            nd += int'(done);
            if (dv === 1'h1)
            begin
                nv++;
                if (first == 0) first = i;
                chk(od === dp, "read data");
            end
            if (busy === 1'h1) chk(bf === ~(sb ? nv >= n : 1'h1) && bfoe === 1'h1, "final");
            dp = d;
        end
        chk(nv == ((sb && !a) ? n + 1 : 1), "beat count");
        chk(first == (e ? 3 : 3 + ws), "ready latency");
        chk(nd == 1, "done");
    endtask : run_cyc

    task automatic nmi_try(input int low, input logic exp);
        @(posedge clk);
        nmi <= 1'h0;
        repeat (low) @(posedge clk);
        nmi <= 1'h1;
        repeat (3) @(posedge clk);
        #1 chk(np === 1'h0, "nmi early");
        @(posedge clk);
        #1 chk(np === exp, "nmi edge");
    endtask : nmi_try

    ////////////////////////////////////////
    initial
    begin
        {rst_n, rstp, irq, nmi, fl, nt, req, bu, mb, afr, hold, early, both} = 13'h0a00;
        {bt, w} = 4'h0;
        void'($urandom(87235));
        repeat (4) @(posedge clk);
        #1 chk(cr === 1'h1 && {bf, lk, bfoe, lkoe} === 4'hc, "reset");
        @(posedge clk);
        rst_n <= 1'h1;
        repeat (10000) @(posedge clk);
        rstp <= 1'h0;
        wait_run();
        run_cyc(1'h1, 2'h3, 2'h0, 1'h1, 1'h0);
        run_cyc(1'h0, 2'h0, 2'h0, 1'h1, 1'h0);
        run_cyc(1'h1, 2'h0, 2'h1, 1'h0, 1'h0);
        run_cyc(1'h1, 2'h3, 2'h3, 1'h0, 1'h1);
        repeat (12) run_cyc(1'($urandom), 2'($urandom), 2'($urandom), 1'h0, 1'($urandom));
        @(posedge clk);
        {hold, req, afr, early, both, mb, w} <= 8'hc1;
        repeat (3) @(posedge clk);
        #1 chk({bfoe, lkoe, busy} === 3'h0, "hold");
        @(posedge clk);
        {hold, req, irq} <= 3'h1;
        repeat (8) @(posedge clk);
        #1 chk(ia === 1'h0 && busy === 1'h0, "masked");
        @(posedge clk);
        fl <= 1'h1;
        nv = 0;
        for (int i = 0; it !== 1'h1; i++)
        begin
            if (i > 40) to_fail();
            @(posedge clk);
            if (ia === 1'h1) fl <= 1'h0;
            #1;
            if (dv === 1'h1) nv++;
            if (ia === 1'h1) chk(lk === 1'h0 && lkoe === 1'h1, "lock");
            if (it === 1'h1) chk(vec === dp[7:0], "vector");
            dp = d;
        end
        chk(nv == 2 && lk === 1'h1 && ia === 1'h0, "ack pair");
        @(posedge clk);
        {irq, fl} <= 2'h0;
        nmi_try(2, 1'h0);
        nmi_try(6, 1'h1);
        @(posedge clk);
        nt <= 1'h1;
        @(posedge clk);
        nt <= 1'h0;
        @(posedge clk);
        #1 chk(np === 1'h0, "nmi clear");
        @(posedge clk);
        rstp <= 1'h1;
        repeat (4) @(posedge clk);
        #1 chk(cr === 1'h1 && busy === 1'h0, "pin reset");
        repeat (12) @(posedge clk);
        rstp <= 1'h0;
        wait_run();
        run_cyc(1'h0, 2'h0, 2'h1, 1'h0, 1'h0);
        end_sim();
    end
endmodule : tb_cycle_termination_and_irq_inputs
